// >>> ahsc_codec.sv
// Acknowledge header builder and command identifier checker with Wishbone registers
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
//
// Summary of operation
// - Header starts with status word, offset 0
// - Offset 2 carries matching acknowledge identifier
// - Offset 4 holds payload byte count
// - Offset 6 echoes the sender's request number
// - Status: low 12 code bits, bit12 zero
// - Bits 13-14 select code namespace
// - Bit 15 severity; warnings still execute
// - Success 0x0000; unknown command 0x8001
// - Bad parameter answers 0x8002
// - Missing register address answers 0x8003
// - Write to read-only answers 0x8004
// - Misaligned address answers 0x8005
// - Wrong-direction access answers 0x8006
// - Busy device answers 0x8007
// - Invalid header answers 0x800E
// - Forbidden by configuration 0x800F; generic 0x8FFF
// - Identifier bit 0: command or acknowledge
// - Identifier bits 1-14 select the type
// - Identifier bit 15 marks custom values
// - Fixed standard identifiers for each command
// - Flag bit 14 requests ack, 15 retry
module ahsc_codec
  import ahsc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [4:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  // Received command header and checks
  input  wire logic                    cmd_valid_i,
  input  wire ahsc_pkg::ahsc_cmd_hdr_s cmd_hdr_i,
  input  wire ahsc_pkg::ahsc_chk_s     cmd_chk_i,
  input  wire logic [15:0]             scd_len_i,
  output logic                         cmd_ready_o,
  // Outgoing acknowledge header
  output logic                         ack_valid_o,
  output ahsc_pkg::ahsc_ack_hdr_s      ack_hdr_o,
  input  wire logic                    ack_ready_i,
  // Execute strobe
  output logic                         exec_o,
  output logic                         exec_write_o
);
  import ahsc_pkg::*;

  function automatic logic [15:0] mk_status(
    input logic        sev,
    input logic [1:0]  ns,
    input logic [11:0] code
  );
    logic [15:0] s;
    s = '0;
    s[ST_CODE_W-1:0]          = code;
    s[ST_RSVD_BIT]            = 1'b0;
    s[ST_NS_LSB+1:ST_NS_LSB]  = ns;
    s[ST_SEV_BIT]             = sev;
    return s;
  endfunction : mk_status

  // Type field of an identifier, without the acknowledge and custom bits
  function automatic logic [ID_VAL_W-1:0] cmd_value(input logic [15:0] id);
    return id[ID_VAL_LSB +: ID_VAL_W];
  endfunction : cmd_value

  function automatic logic is_write_id(input logic [15:0] id);
    return (id == ID_WRITE) || (id == ID_SWRITE);
  endfunction : is_write_id

  // Error severity; a warning still lets the command run
  function automatic logic last_bad_of(input logic [15:0] s);
    return s[ST_SEV_BIT];
  endfunction : last_bad_of

  function automatic logic is_known_cmd(
    input logic [15:0] id,
    input logic        cust_en
  );
    logic k;
    k = 1'b0;
    // An acknowledge identifier is never a valid command
    if (id[ID_ACK_BIT])
      k = 1'b0;
    else if (id[ID_CUST_BIT])
      k = cust_en;
    else
    begin
      // Event commands travel the other way and are not accepted here
      k = (cmd_value(id) == cmd_value(ID_READ))   ||
          (cmd_value(id) == cmd_value(ID_WRITE))  ||
          (cmd_value(id) == cmd_value(ID_SREAD))  ||
          (cmd_value(id) == cmd_value(ID_SWRITE));
    end
    return k;
  endfunction : is_known_cmd

  function automatic logic [7:0] hdr_byte(
    input ahsc_ack_hdr_s h,
    input int            idx
  );
    logic [15:0] w;
    w = h.req_id;
    if (idx < HDR_OFS_ID)
      w = h.status;
    else if (idx < HDR_OFS_LEN)
      w = h.cmd_id;
    else if (idx < HDR_OFS_REQ)
      w = h.length;
    return (idx % 2 == 0) ? w[7:0] : w[15:8];
  endfunction : hdr_byte

  // Four header bytes from a byte offset, lowest byte in bits 7:0
  function automatic logic [31:0] hdr_word(
    input ahsc_ack_hdr_s h,
    input int            base
  );
    return {hdr_byte(h, base + 3), hdr_byte(h, base + 2),
            hdr_byte(h, base + 1), hdr_byte(h, base)};
  endfunction : hdr_word

  // Command path state
  ahsc_state_e         state;
  ahsc_state_e         next_state;
  ahsc_ack_hdr_s       ack_hdr;
  ahsc_ack_hdr_s       next_ack_hdr;
  logic                exec;
  logic                next_exec;
  logic                exec_wr;
  logic                next_exec_wr;
  logic [15:0]         last_status;
  logic [15:0]         next_last_status;
  logic [15:0]         last_id;
  logic [15:0]         next_last_id;

  // Register state
  logic [CTRL_W-1:0]   ctrl;
  logic [CTRL_W-1:0]   next_ctrl;
  logic [15:0]         cmd_cnt;
  logic [15:0]         next_cmd_cnt;
  logic [7:0]          err_cnt;
  logic [7:0]          next_err_cnt;
  logic [7:0]          retry_cnt;
  logic [7:0]          next_retry_cnt;
  logic                wb_ack;
  logic                next_wb_ack;
  logic [31:0]         rdata;
  logic [31:0]         next_rdata;

  logic                take;
  logic [15:0]         status;
  logic                wr_cmd;
  logic                wb_req;
  logic                wr_now;

  assign cmd_ready_o  = (state == ST_IDLE);
  assign take         = cmd_valid_i && cmd_ready_o;
  assign wr_cmd       = is_write_id(cmd_hdr_i.cmd_id);
  assign ack_valid_o  = (state == ST_SEND);
  assign ack_hdr_o    = ack_hdr;
  assign exec_o       = exec;
  assign exec_write_o = exec_wr;
  assign ack_o        = wb_ack;
  assign dat_o        = rdata;
  assign wb_req       = cyc_i && stb_i;
  assign wr_now       = wb_ack && wb_req && we_i;

  // Status selection, one code by fixed priority
  always_comb
  begin
    status = ST_SUCCESS;
    if (cmd_chk_i.size_bad || ((cmd_hdr_i.flags & FLG_RSVD_MASK) != '0))
      status = ST_BAD_HDR;
    else if (!is_known_cmd(cmd_hdr_i.cmd_id, ctrl[CTRL_CUST_BIT]))
      status = ST_NOT_IMPL;
    else if (cmd_chk_i.len_bad || cmd_chk_i.rsvd_bad ||
             (wr_cmd && cmd_hdr_i.req_id == '0))
      status = ST_BAD_PARAM;
    else if (cmd_chk_i.busy || ctrl[CTRL_BUSY_BIT])
      status = ST_BUSY;
    else if (wr_cmd && ctrl[CTRL_LOCK_BIT])
      status = ST_WRONG_CFG;
    else if (cmd_chk_i.addr_missing)
      status = ST_BAD_ADDR;
    else if (cmd_chk_i.misaligned)
      status = ST_BAD_ALIGN;
    else if (wr_cmd && cmd_chk_i.read_only)
      status = ST_WR_PROT;
    else if (cmd_chk_i.no_access)
      status = ST_NO_ACCESS;
    else if (cmd_chk_i.dev_err)
      status = mk_status(1'b1, NS_DEV, cmd_chk_i.dev_code);
    else if (cmd_chk_i.generic)
      status = ST_GENERIC;
    else if (cmd_chk_i.warn)
      status = mk_status(1'b0, NS_DEV, cmd_chk_i.dev_code);
  end

  // Command path next values
  always_comb
  begin
    next_state       = state;
    next_ack_hdr     = ack_hdr;
    next_exec        = 1'b0;
    next_exec_wr     = 1'b0;
    next_last_status = last_status;
    next_last_id     = last_id;
    unique case (state)
      ST_IDLE:
      begin
        if (take)
        begin
          next_ack_hdr.status = status;
          next_ack_hdr.cmd_id = cmd_hdr_i.cmd_id | 16'h0001;
          next_ack_hdr.length = status[ST_SEV_BIT] ? 16'h0000 : scd_len_i;
          next_ack_hdr.req_id = cmd_hdr_i.req_id;
          next_last_status    = status;
          next_last_id        = cmd_hdr_i.cmd_id;
          next_exec           = !status[ST_SEV_BIT];
          next_exec_wr        = !status[ST_SEV_BIT] && wr_cmd;
          // Without an ack request the status is only recorded
          if (cmd_hdr_i.flags[FLG_ACKREQ_BIT])
            next_state = ST_SEND;
        end
      end
      ST_SEND:
      begin
        // Header stays frozen until the host takes it
        if (ack_ready_i)
          next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state       <= ST_IDLE;
      ack_hdr     <= '0;
      exec        <= 1'b0;
      exec_wr     <= 1'b0;
      last_status <= ST_SUCCESS;
      last_id     <= 16'h0000;
    end
    else
    begin
      state       <= next_state;
      ack_hdr     <= next_ack_hdr;
      exec        <= next_exec;
      exec_wr     <= next_exec_wr;
      last_status <= next_last_status;
      last_id     <= next_last_id;
    end
  end

  // Bus handshake and read data next values
  always_comb
  begin
    next_wb_ack = wb_req && !wb_ack;
    next_rdata  = rdata;
    // Read data is captured as the request arrives and stands with ack_o
    if (wb_req && !wb_ack)
    begin
      unique case (adr_i)
        REG_CTRL:   next_rdata = {29'h0, ctrl};
        REG_STAT:   next_rdata = {last_id, last_status};
        REG_CNT:    next_rdata = {retry_cnt, err_cnt, cmd_cnt};
        REG_HDR_LO: next_rdata = hdr_word(ack_hdr, HDR_OFS_STAT);
        REG_HDR_HI: next_rdata = hdr_word(ack_hdr, HDR_OFS_LEN);
        default:    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack <= 1'b0;
      rdata  <= 32'h0000_0000;
    end
    else
    begin
      wb_ack <= next_wb_ack;
      rdata  <= next_rdata;
    end
  end

  // Control register and event counters next values
  always_comb
  begin
    next_ctrl      = ctrl;
    next_cmd_cnt   = cmd_cnt;
    next_err_cnt   = err_cnt;
    next_retry_cnt = retry_cnt;
    // Writes commit on the edge at which the master sees ack_o
    if (wr_now && adr_i == REG_CTRL && sel_i[0])
      next_ctrl = dat_i[CTRL_W-1:0];
    // Clearing counters loses no event in the same cycle
    if (wr_now && adr_i == REG_CNT)
    begin
      next_cmd_cnt   = '0;
      next_err_cnt   = '0;
      next_retry_cnt = '0;
    end
    if (take)
      next_cmd_cnt = next_cmd_cnt + 16'h0001;
    if (take && last_bad_of(status))
      next_err_cnt = next_err_cnt + 8'h01;
    if (take && cmd_hdr_i.flags[FLG_RETRY_BIT])
      next_retry_cnt = next_retry_cnt + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl      <= CTRL_RST;
      cmd_cnt   <= 16'h0000;
      err_cnt   <= 8'h00;
      retry_cnt <= 8'h00;
    end
    else
    begin
      ctrl      <= next_ctrl;
      cmd_cnt   <= next_cmd_cnt;
      err_cnt   <= next_err_cnt;
      retry_cnt <= next_retry_cnt;
    end
  end

endmodule : ahsc_codec

// >>> ahsc_pkg.sv
// Constants, types and field layouts of the acknowledge header codec
package ahsc_pkg;

  // Register byte offsets
  localparam logic [4:0]  REG_CTRL      = 5'h00;
  localparam logic [4:0]  REG_STAT      = 5'h04;
  localparam logic [4:0]  REG_CNT       = 5'h08;
  localparam logic [4:0]  REG_HDR_LO    = 5'h0C;
  localparam logic [4:0]  REG_HDR_HI    = 5'h10;

  // Control register layout
  localparam int          CTRL_BUSY_BIT = 0;
  localparam int          CTRL_CUST_BIT = 1;
  localparam int          CTRL_LOCK_BIT = 2;
  localparam int          CTRL_W        = 3;
  localparam logic [2:0]  CTRL_RST      = 3'h0;

  // Header byte offsets
  localparam int          HDR_OFS_STAT  = 0;
  localparam int          HDR_OFS_ID    = 2;
  localparam int          HDR_OFS_LEN   = 4;
  localparam int          HDR_OFS_REQ   = 6;

  // Status word layout
  localparam int          ST_CODE_W     = 12;
  localparam int          ST_RSVD_BIT   = 12;
  localparam int          ST_NS_LSB     = 13;
  localparam int          ST_SEV_BIT    = 15;
  localparam logic [1:0]  NS_PROTO      = 2'h0;
  localparam logic [1:0]  NS_TECH       = 2'h1;
  localparam logic [1:0]  NS_DEV        = 2'h2;

  // Status codes
  localparam logic [15:0] ST_SUCCESS    = 16'h0000;
  localparam logic [15:0] ST_NOT_IMPL   = 16'h8001;
  localparam logic [15:0] ST_BAD_PARAM  = 16'h8002;
  localparam logic [15:0] ST_BAD_ADDR   = 16'h8003;
  localparam logic [15:0] ST_WR_PROT    = 16'h8004;
  localparam logic [15:0] ST_BAD_ALIGN  = 16'h8005;
  localparam logic [15:0] ST_NO_ACCESS  = 16'h8006;
  localparam logic [15:0] ST_BUSY       = 16'h8007;
  localparam logic [15:0] ST_TIMEOUT    = 16'h800B;
  localparam logic [15:0] ST_BAD_HDR    = 16'h800E;
  localparam logic [15:0] ST_WRONG_CFG  = 16'h800F;
  localparam logic [15:0] ST_GENERIC    = 16'h8FFF;

  // Command identifier layout
  localparam int          ID_ACK_BIT    = 0;
  localparam int          ID_VAL_LSB    = 1;
  localparam int          ID_VAL_W      = 14;
  localparam int          ID_CUST_BIT   = 15;
  localparam logic [15:0] ID_READ       = 16'h0800;
  localparam logic [15:0] ID_READ_ACK   = 16'h0801;
  localparam logic [15:0] ID_WRITE      = 16'h0802;
  localparam logic [15:0] ID_WRITE_ACK  = 16'h0803;
  localparam logic [15:0] ID_PEND_ACK   = 16'h0805;
  localparam logic [15:0] ID_SREAD      = 16'h0806;
  localparam logic [15:0] ID_SREAD_ACK  = 16'h0807;
  localparam logic [15:0] ID_SWRITE     = 16'h0808;
  localparam logic [15:0] ID_SWRITE_ACK = 16'h0809;
  localparam logic [15:0] ID_EVENT      = 16'h0C00;
  localparam logic [15:0] ID_EVENT_ACK  = 16'h0C01;

  // Command flags layout
  localparam int          FLG_ACKREQ_BIT = 14;
  localparam int          FLG_RETRY_BIT  = 15;
  localparam logic [15:0] FLG_RSVD_MASK  = 16'h3FFF;

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] cmd_id;
    logic [15:0] length;
    logic [15:0] req_id;
  } ahsc_cmd_hdr_s;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] cmd_id;
    logic [15:0] length;
    logic [15:0] req_id;
  } ahsc_ack_hdr_s;

  typedef struct packed {
    logic        size_bad;
    logic        len_bad;
    logic        rsvd_bad;
    logic        addr_missing;
    logic        read_only;
    logic        misaligned;
    logic        no_access;
    logic        busy;
    logic        dev_err;
    logic        generic;
    logic        warn;
    logic [11:0] dev_code;
  } ahsc_chk_s;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } ahsc_state_e;

endpackage : ahsc_pkg

// >>> ahsc_codec_asserts.sv
// Port-level checks of the acknowledge header codec
`timescale 1ns/1ps
module ahsc_codec_asserts
  import ahsc_pkg::*;
(
  // Clock, reset and bus
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    cyc_i,
  input wire logic                    stb_i,
  input wire logic                    ack_o,
  // Command and acknowledge
  input wire logic                    cmd_valid_i,
  input wire ahsc_pkg::ahsc_cmd_hdr_s cmd_hdr_i,
  input wire ahsc_pkg::ahsc_chk_s     cmd_chk_i,
  input wire logic                    cmd_ready_o,
  input wire logic                    ack_valid_o,
  input wire ahsc_pkg::ahsc_ack_hdr_s ack_hdr_o,
  input wire logic                    ack_ready_i,
  input wire logic                    exec_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cmd_valid_i && cmd_ready_o;
  endsequence
  sequence s_take_ack;
    s_take ##0 cmd_hdr_i.flags[FLG_ACKREQ_BIT];
  endsequence
  a_wb_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("bus ack late");
  a_wb_ack_pulse: assert property (ack_o |=> !ack_o) else $error("bus ack too long");
  a_hdr_hold: assert property (ack_valid_o && !ack_ready_i |=> ack_valid_o && $stable(ack_hdr_o))
    else $error("ack header moved while waiting");
  a_echo_ids: assert property (s_take_ack |=> ack_valid_o && ack_hdr_o.req_id == $past(cmd_hdr_i.req_id)
    && ack_hdr_o.cmd_id == ($past(cmd_hdr_i.cmd_id) | 16'h0001)) else $error("ack ids wrong");
  a_rsvd_zero: assert property (ack_valid_o |-> !ack_hdr_o.status[ST_RSVD_BIT])
    else $error("status reserved bit set");
  a_ns_legal: assert property (ack_valid_o |-> ack_hdr_o.status[14:13] != 2'h3)
    else $error("status namespace illegal");
  a_ack_flag: assert property (ack_valid_o |-> ack_hdr_o.cmd_id[ID_ACK_BIT])
    else $error("ack id bit 0 clear");
  a_exec_sev: assert property (s_take_ack |=> exec_o == !ack_hdr_o.status[ST_SEV_BIT])
    else $error("execute strobe disagrees with severity");
  a_err_len: assert property (ack_valid_o && ack_hdr_o.status[ST_SEV_BIT] |-> ack_hdr_o.length == 16'h0000)
    else $error("error ack carries length");
  a_hdr_first: assert property (s_take_ack ##0 cmd_chk_i.size_bad |=> ack_hdr_o.status == ST_BAD_HDR)
    else $error("header fault not reported first");
  a_no_ack: assert property (s_take ##0 !cmd_hdr_i.flags[FLG_ACKREQ_BIT] |=> !ack_valid_o)
    else $error("ack sent without request");
endmodule : ahsc_codec_asserts

// >>> ahsc_host.sv
// Host model: sends command headers and takes acknowledge headers
`timescale 1ns/1ps
module ahsc_host
  import ahsc_pkg::*;
(
  // Clock
  input  wire logic                    clk_i,
  // Command side
  output ahsc_pkg::ahsc_cmd_hdr_s      cmd_hdr_o,
  output ahsc_pkg::ahsc_chk_s          cmd_chk_o,
  output logic [15:0]                  scd_len_o,
  output logic                         cmd_valid_o,
  input  wire logic                    cmd_ready_i,
  // Acknowledge side
  input  wire logic                    ack_valid_i,
  input  wire ahsc_pkg::ahsc_ack_hdr_s ack_hdr_i,
  output logic                         ack_ready_o
);
  initial
  begin
    cmd_hdr_o = '0;
    cmd_chk_o = '0;
    scd_len_o = '0;
    cmd_valid_o = 1'b0;
    ack_ready_o = 1'b0;
  end
  // Cycles the host waits for an acknowledge before it gives up
  localparam int ACK_WAIT = 16;
  task automatic send(input ahsc_cmd_hdr_s h, input ahsc_chk_s c, input int stall, output ahsc_ack_hdr_s got);
    int waited;
    got = '0;
    waited = 0;
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_hdr_o   <= h;
    cmd_chk_o   <= c;
    // Payload size follows the request number so that it is never a constant
    scd_len_o   <= 16'h0020 + h.req_id;
    #1;
    while (!cmd_ready_i)
    begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    // Released lines show the inverse so stale values cannot pass
    cmd_valid_o <= 1'b0;
    cmd_hdr_o   <= ~h;
    cmd_chk_o   <= ~c;
    if (h.flags[FLG_ACKREQ_BIT])
    begin
      repeat (stall) @(posedge clk_i);
      ack_ready_o <= 1'b1;
      #1;
      while (!ack_valid_i && waited < ACK_WAIT)
      begin
        @(posedge clk_i);
        #1;
        waited++;
      end
      // A missing acknowledge is reported with the sender's timeout status
      if (ack_valid_i)
        got = ack_hdr_i;
      else
        got.status = ST_TIMEOUT;
      @(posedge clk_i);
      ack_ready_o <= 1'b0;
    end
  endtask : send
endmodule : ahsc_host

// >>> tb.sv
// Self-checking testbench of the acknowledge header codec
`timescale 1ns/1ps
module tb;
  import ahsc_pkg::*;
  logic          clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cmd_valid_i, cmd_ready_o;
  logic          ack_valid_o, ack_ready_i, exec_o, exec_write_o;
  logic [4:0]    adr_i;
  logic [3:0]    sel_i;
  logic [31:0]   dat_i, dat_o, q;
  logic [15:0]   scd_len_i;
  ahsc_cmd_hdr_s cmd_hdr_i;
  ahsc_chk_s     cmd_chk_i;
  ahsc_ack_hdr_s ack_hdr_o, g;
  int            n_mismatch, n_checks, n_exec, n_wexec;
  logic [15:0]   ids [4] = '{ID_READ, ID_WRITE, ID_SREAD, ID_SWRITE};

  ahsc_codec dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .cmd_valid_i,
    .cmd_hdr_i, .cmd_chk_i, .scd_len_i, .cmd_ready_o, .ack_valid_o, .ack_hdr_o, .ack_ready_i, .exec_o, .exec_write_o);
  ahsc_host host (.clk_i, .cmd_hdr_o(cmd_hdr_i), .cmd_chk_o(cmd_chk_i), .scd_len_o(scd_len_i),
    .cmd_valid_o(cmd_valid_i), .cmd_ready_i(cmd_ready_o), .ack_valid_i(ack_valid_o), .ack_hdr_i(ack_hdr_o),
    .ack_ready_o(ack_ready_i));

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    n_exec += int'(exec_o === 1'b1);
    n_wexec += int'(exec_write_o === 1'b1);
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    #1;
    while (ack_o !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
    end
    q = dat_o;
    @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  function automatic ahsc_chk_s ck(input int k, input logic [11:0] code);
    ck = '0;
    if (k < 23)
      ck[k] = 1'b1;
    ck.dev_code = code;
  endfunction : ck

  task automatic cmd(input logic [15:0] fl, id, rq, input ahsc_chk_s c, input logic [15:0] est, input int stall);
    int e0, w0;
    e0 = n_exec;
    w0 = n_wexec;
    host.send({fl, id, 16'h0008, rq}, c, stall, g);
    repeat (2) @(posedge clk_i);
    #1;
    chk("status", est, g.status);
    chk("ack id", id | 16'h0001, g.cmd_id);
    chk("length", est[15] ? 16'h0000 : 16'h0020 + rq, g.length);
    chk("req id", rq, g.req_id);
    chk("exec", !est[15], n_exec - e0);
    chk("exec write", !est[15] && (id == ID_WRITE || id == ID_SWRITE), n_wexec - w0);
  endtask : cmd

  task automatic t_ok;
    foreach (ids[i]) cmd(16'h4000, ids[i], 16'h0010 + i, ck(23, 0), ST_SUCCESS, i);
    wb(0, REG_HDR_LO, 0, 4'hF);
    chk("hdr lo", {ID_SWRITE_ACK, ST_SUCCESS}, q);
    wb(0, REG_HDR_HI, 0, 4'hF);
    chk("hdr hi", 32'h0013_0033, q);
    cmd(16'hC000, ID_READ, 16'h0014, ck(12, 12'h123), 16'h4123, 2);
    $display("test success done");
  endtask : t_ok

  task automatic t_err;
    cmd(16'h4000, ID_READ, 16'h0020, ck(22, 0), ST_BAD_HDR, 0);
    cmd(16'h4002, ID_READ, 16'h0021, ck(19, 0), ST_BAD_HDR, 1);
    cmd(16'h4000, ID_READ_ACK, 16'h0022, ck(23, 0), ST_NOT_IMPL, 0);
    cmd(16'h4000, 16'h0804, 16'h0023, ck(23, 0), ST_NOT_IMPL, 0);
    cmd(16'h4000, 16'h8800, 16'h0024, ck(23, 0), ST_NOT_IMPL, 0);
    cmd(16'h4000, ID_EVENT, 16'h0025, ck(23, 0), ST_NOT_IMPL, 0);
    cmd(16'h4000, ID_READ, 16'h0026, ck(21, 0), ST_BAD_PARAM, 0);
    cmd(16'h4000, ID_READ, 16'h0027, ck(20, 0), ST_BAD_PARAM, 0);
    cmd(16'h4000, ID_WRITE, 16'h0000, ck(23, 0), ST_BAD_PARAM, 0);
    cmd(16'h4000, ID_READ, 16'h0028, ck(19, 0), ST_BAD_ADDR, 0);
    cmd(16'h4000, ID_WRITE, 16'h0029, ck(18, 0), ST_WR_PROT, 0);
    cmd(16'h4000, ID_READ, 16'h002A, ck(17, 0), ST_BAD_ALIGN, 0);
    cmd(16'h4000, ID_READ, 16'h002B, ck(16, 0), ST_NO_ACCESS, 0);
    cmd(16'h4000, ID_READ, 16'h002C, ck(15, 0), ST_BUSY, 0);
    cmd(16'h4000, ID_READ, 16'h002D, ck(14, 12'h055), 16'hC055, 0);
    cmd(16'h4000, ID_READ, 16'h002E, ck(13, 0), ST_GENERIC, 0);
    $display("test errors done");
  endtask : t_err

  task automatic t_ctrl;
    wb(1, REG_CTRL, 32'h1, 4'h0);
    wb(0, REG_CTRL, 0, 4'hF);
    chk("ctrl", 0, q);
    wb(1, REG_CTRL, 32'h1, 4'h1);
    cmd(16'h4000, ID_READ, 16'h0030, ck(23, 0), ST_BUSY, 0);
    wb(1, REG_CTRL, 32'h4, 4'h1);
    cmd(16'h4000, ID_WRITE, 16'h0031, ck(23, 0), ST_WRONG_CFG, 0);
    wb(1, REG_CTRL, 32'h2, 4'h1);
    cmd(16'h4000, 16'h8800, 16'h0032, ck(23, 0), ST_SUCCESS, 0);
    wb(1, REG_CTRL, 32'h0, 4'h1);
    wb(0, 5'h14, 0, 4'hF);
    chk("unmapped", 0, q);
    host.send({16'h0000, ID_READ, 16'h0008, 16'h0033}, ck(19, 0), 0, g);
    repeat (3)
    begin
      @(posedge clk_i);
      #1;
      chk("ack valid", 0, ack_valid_o);
    end
    wb(0, REG_STAT, 0, 4'hF);
    chk("stat", ST_BAD_ADDR, q[15:0]);
    $display("test control done");
  endtask : t_ctrl

  task automatic t_cnt;
    wb(0, REG_CNT, 0, 4'hF);
    chk("counters", 32'h0113_0019, q);
    wb(1, REG_CTRL, 32'h7, 4'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, REG_CTRL, 0, 4'hF);
    chk("ctrl after reset", 0, q);
    cmd(16'hC000, ID_READ, 16'h0040, ck(23, 0), ST_SUCCESS, 0);
    wb(0, REG_CNT, 0, 4'hF);
    chk("counters after reset", 32'h0100_0001, q);
    wb(1, REG_CNT, 0, 4'h0);
    wb(0, REG_CNT, 0, 4'hF);
    chk("counters clear", 0, q);
    $display("test counters done");
  endtask : t_cnt

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  initial
  begin
    {clk_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    {n_mismatch, n_checks, n_exec, n_wexec} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("cmd ready", 1, cmd_ready_o);
    t_ok;
    t_err;
    t_ctrl;
    t_cnt;
    final_report;
  end

  initial
  begin
    #500000;
    n_mismatch++;
    final_report;
  end
endmodule : tb

bind ahsc_codec ahsc_codec_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .cmd_valid_i, .cmd_hdr_i,
  .cmd_chk_i, .cmd_ready_o, .ack_valid_o, .ack_hdr_o, .ack_ready_i, .exec_o);
